/* shared/cpu_bus_defs.vh */
// Constants for the local-bus interface block.
// Assumes inclusion by bare name from design files.
`ifndef CPU_BUS_DEFS_VH
`define CPU_BUS_DEFS_VH
// Register byte addresses
`define REG_CTRL       12'h000
`define REG_CYCLE      12'h004
`define REG_ADDR       12'h008
`define REG_WDATA      12'h00C
`define REG_RDATA      12'h010
`define REG_STATUS     12'h014
`define REG_CFG_A      12'h018
`define REG_CFG_B      12'h01C
`define REG_IRQ        12'h020
// Configuration bits, cache_config_reg_a
`define CFG_A_KEN      0
`define CFG_A_FLUSH    1
`define CFG_A_GRANT    2
// Configuration bits, cache_config_reg_b
`define CFG_B_RPL      0
`define CFG_B_TWOWAY   1
// Control register bits
`define CTRL_GO        0
`define CTRL_IE        1
`define CTRL_INTERRUPT_RETURN_INSTR      2
`define CTRL_HALT      3
`define CTRL_SHUT      4
`define CTRL_INTA      5
// Cycle type codes: mem_io, data_ctl, wr_rd, lock_n
`define CYC_INTA       4'b0000
`define CYC_IO_RD      4'b0101
`define CYC_IO_WR      4'b0111
`define CYC_CODE_RD    4'b1001
`define CYC_HALT       4'b1011
`define CYC_LK_RD      4'b1100
`define CYC_MEM_RD     4'b1101
`define CYC_LK_WR      4'b1110
`define CYC_MEM_WR     4'b1111
// Halt, shutdown and all-byte enables; non-maskable vector
`define BE_HALT        4'b1011
`define BE_SHUT        4'b1110
`define BE_ALL         4'b0000
`define NMI_VECTOR     8'h02
// Noise filter length, double-rate clocks
`define NMI_MIN_DOUBLE_RATE_CLOCK   8
`endif

/* design/clk_phase.v */
// Divides the double-rate clock into processor phases.
// Assumes pclk is the double-rate clock; phase realigns when reset falls.
`timescale 1ns/100ps
module clk_phase (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Phase out
  output reg  phase2
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase2 <= 1'b0;
    end else begin
      phase2 <= ~phase2;
    end
  end
endmodule

/* design/nmi_catch.v */
// Non-maskable interrupt edge catcher with one stored pending edge.
// Assumes nmi is synchronous to pclk and sampled on phase2.
`timescale 1ns/100ps
`include "cpu_bus_defs.vh"
module nmi_catch #(
  parameter MIN_DOUBLE_RATE_CLOCK = `NMI_MIN_DOUBLE_RATE_CLOCK
) (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Control
  input  wire phase2,
  input  wire nmi,
  input  wire take,
  input  wire interrupt_return_instr,
  // Status
  output reg  pending,
  output reg  in_service
);
  reg [3:0] low_cnt;
  reg [3:0] high_cnt;
  reg       armed;
  wire      edge_seen;
  // stable low then high
  // Threshold or beyond, so a phase-2 sample is never missed
  assign edge_seen = phase2 && nmi && armed && (high_cnt >= (MIN_DOUBLE_RATE_CLOCK[3:0] - 4'd1));
  // Filter counts in double-rate clocks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt  <= 4'h0;
      high_cnt <= 4'h0;
      armed    <= 1'b0;
    end else begin
      if (nmi) begin
        low_cnt  <= 4'h0;
        if (high_cnt != 4'hF)
          high_cnt <= high_cnt + 4'd1;
        if (edge_seen)
          armed <= 1'b0;
      end else begin
        high_cnt <= 4'h0;
        if (low_cnt != 4'hF)
          low_cnt <= low_cnt + 4'd1;
        if (low_cnt >= MIN_DOUBLE_RATE_CLOCK[3:0] - 4'd1)
          armed <= 1'b1;
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending    <= 1'b0;
      in_service <= 1'b0;
    end else begin
      if (edge_seen)
        pending <= 1'b1;
      else if (take)
        pending <= 1'b0;
      if (take)
        in_service <= 1'b1;
      else if (interrupt_return_instr)
        in_service <= 1'b0;
    end
  end
endmodule

/* design/local_bus_if.v */
// Local-bus interface of a 32-bit processor, driven by an APB command port.
// Assumes pins synchronous to pclk (the double-rate clock); APB master.
//
// Overview of operation
// - Data lines input on reads and acknowledges, driven on writes.
// - Bus grant floats data, cycle definition and address strobe.
// - Cycle definition valid with strobe; lock valid from cycle start.
// - Cycle type is the four-bit code written by software; it is not checked against the nine documented codes.
// - Halt and shutdown drive zero address with their byte enables.
// - Lock asserted for locked, exchange, descriptor and acknowledge cycles.
// - No bus grant while lock is active.
// - Strobe for first clock; pipelined strobe held until ready.
// - Ready ends every cycle; read data captured on ready.
// - Next address request lets the next cycle start early.
// - Narrow bus size splits memory access into 16-bit halves on low lines.
// - Unmasked maskable request yields two locked acknowledge cycles.
// - Non-maskable edge enters service with internal vector 2.
// - Further non-maskable edges blocked until return; one is stored.
// - Maskable request serviced inside non-maskable service.
// - Halt in non-maskable service resumes only on maskable request.
// - Non-maskable input sampled each phase 2, eight clocks each level.
// - Cacheable unlocked memory reads with cache enable become fills; halt and acknowledge cycles do too while the written type is such a read.
// - Full-width fills ignore byte enables, all four bytes stored.
// - Cache enable and flush ignored until enabled; grant may flush.
// - Replacement outputs float until enabled and while granted; valid the clock after a fill ends.
// - Internal clock is the double-rate clock divided by two.
`timescale 1ns/100ps
`include "cpu_bus_defs.vh"
module local_bus_if (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Data lines
  input  wire [31:0] data_in,
  output reg  [31:0] data_out,
  output reg         data_oe_n,
  // Address and cycle definition
  output reg  [29:0] addr_out,
  output reg  [3:0]  byte_en_n,
  output reg         mem_io,
  output reg         data_ctl,
  output reg         wr_rd,
  output reg         lock_n,
  output reg         addr_strobe_n,
  output reg         def_oe_n,
  // Bus cycle control
  input  wire        ready_n,
  input  wire        next_addr_req_n,
  input  wire        narrow_bus_size_n,
  // Arbitration
  input  wire        hold_req,
  output reg         bus_grant_ack,
  // Interrupts
  input  wire        maskable_irq,
  input  wire        nmi,
  // Cache interface
  input  wire        cacheable_n,
  input  wire        flush_n,
  output reg         replace_way,
  output reg         replace_way_valid_n,
  output reg         replace_oe_n,
  output reg         cache_flush
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_ADDR  = 3'd1;
  localparam ST_WAIT  = 3'd2;
  localparam ST_GRANT = 3'd3;
  localparam ST_INTA2 = 3'd4;

  reg [2:0]  state;
  reg [31:0] ctrl;
  reg [3:0]  cyc_type;
  reg [29:0] req_addr;
  reg [31:0] wdata;
  reg [31:0] rdata;
  reg [7:0]  cfg_a;
  reg [7:0]  cfg_b;
  reg [7:0]  vector;
  reg        busy;
  reg        half;
  reg        fill_ok;
  reg        fill_done;
  reg        way;
  reg        piped;
  reg        irq_taken;
  reg        halted;
  wire       phase2;
  wire       nmi_pend;
  wire       nmi_serv;
  wire       apb_wr;
  wire       done;
  wire       is_read;
  wire       take_nmi;

  // Decodes read-class cycles, used by the read-data capture only
  function rd_cycle;
    input [3:0] t;
    begin
      rd_cycle = (t == `CYC_INTA) || (t == `CYC_IO_RD) || (t == `CYC_CODE_RD) ||
                 (t == `CYC_LK_RD) || (t == `CYC_MEM_RD);
    end
  endfunction

  // Only a written type of plain memory code or data read may fill the cache
  function fillable;
    input [3:0] t;
    begin
      fillable = (t == `CYC_CODE_RD) || (t == `CYC_MEM_RD);
    end
  endfunction

  clk_phase u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .phase2  (phase2)
  );

  assign take_nmi = nmi_pend && !nmi_serv && (state == ST_IDLE) && !busy;

  nmi_catch #(
    .MIN_DOUBLE_RATE_CLOCK (`NMI_MIN_DOUBLE_RATE_CLOCK)
  ) u_nmi (
    .pclk       (pclk),
    .presetn    (presetn),
    .phase2     (phase2),
    .nmi        (nmi),
    .take       (take_nmi),
    .interrupt_return_instr       (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_INTERRUPT_RETURN_INSTR]),
    .pending    (nmi_pend),
    .in_service (nmi_serv)
  );

  assign apb_wr  = psel && penable && pwrite && pready;
  assign done    = (state == ST_WAIT || state == ST_INTA2) && !ready_n;
  assign is_read = rd_cycle(cyc_type);

  // APB: one wait state, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pslverr <= 1'b0;
        case (paddr)
          `REG_CTRL:   prdata <= ctrl;
          `REG_CYCLE:  prdata <= {28'h000_0000, cyc_type};
          `REG_ADDR:   prdata <= {req_addr, 2'b00};
          `REG_WDATA:  prdata <= wdata;
          `REG_RDATA:  prdata <= rdata;
          `REG_STATUS: prdata <= {25'h000_0000, halted, nmi_serv, nmi_pend,
                                  fill_done, bus_grant_ack, busy, state[2]};
          `REG_CFG_A:  prdata <= {24'h00_0000, cfg_a};
          `REG_CFG_B:  prdata <= {24'h00_0000, cfg_b};
          `REG_IRQ:    prdata <= {24'h00_0000, vector};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // Register writes from software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= 32'h0000_0000;
      cyc_type <= `CYC_MEM_RD;
      req_addr <= 30'h0000_0000;
      wdata    <= 32'h0000_0000;
      cfg_a    <= 8'h00;
      cfg_b    <= 8'h00;
    end else if (apb_wr) begin
      case (paddr)
        `REG_CTRL:  ctrl     <= pwdata & 32'h0000_003B;
        `REG_CYCLE: cyc_type <= pwdata[3:0];
        `REG_ADDR:  req_addr <= pwdata[31:2];
        `REG_WDATA: wdata    <= pwdata;
        `REG_CFG_A: cfg_a    <= pwdata[7:0];
        `REG_CFG_B: cfg_b    <= pwdata[7:0];
        default:    ctrl     <= ctrl;
      endcase
    end else begin
      ctrl[`CTRL_GO] <= ctrl[`CTRL_GO] && !(state == ST_IDLE && !busy);
    end
  end

  // Bus cycle sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state               <= ST_IDLE;
      busy                <= 1'b0;
      half                <= 1'b0;
      piped               <= 1'b0;
      rdata               <= 32'h0000_0000;
      vector              <= 8'h00;
      irq_taken           <= 1'b0;
      halted              <= 1'b0;
      fill_ok             <= 1'b0;
      fill_done           <= 1'b0;
      way                 <= 1'b0;
      data_out            <= 32'h0000_0000;
      data_oe_n           <= 1'b1;
      addr_out            <= 30'h3FFF_FFFF;
      byte_en_n           <= 4'h0;
      mem_io              <= 1'b0;
      data_ctl            <= 1'b1;
      wr_rd               <= 1'b0;
      lock_n              <= 1'b1;
      addr_strobe_n       <= 1'b1;
      def_oe_n            <= 1'b0;
      bus_grant_ack       <= 1'b0;
      replace_way         <= 1'b0;
      replace_way_valid_n <= 1'b1;
      replace_oe_n        <= 1'b1;
      cache_flush         <= 1'b0;
    end else begin
      replace_oe_n <= !(cfg_b[`CFG_B_RPL] && !bus_grant_ack);
      cache_flush  <= (cfg_a[`CFG_A_FLUSH] && !flush_n) ||
                      (cfg_a[`CFG_A_GRANT] && state == ST_IDLE && hold_req && lock_n);
      if (take_nmi)
        vector <= `NMI_VECTOR;
      if (state == ST_IDLE && maskable_irq && ctrl[`CTRL_IE])
        halted <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (hold_req && lock_n) begin
            state         <= ST_GRANT;
            bus_grant_ack <= 1'b1;
            def_oe_n      <= 1'b1;
            data_oe_n     <= 1'b1;
          end else if (maskable_irq && ctrl[`CTRL_IE] && !irq_taken) begin
            irq_taken     <= 1'b1;
            busy          <= 1'b1;
            state         <= ST_ADDR;
            {mem_io, data_ctl, wr_rd, lock_n} <= `CYC_INTA;
            addr_out      <= 30'h0000_0000;
            byte_en_n     <= `BE_ALL;
          end else if (ctrl[`CTRL_GO] && !halted) begin
            busy      <= 1'b1;
            half      <= 1'b0;
            state     <= ST_ADDR;
            fill_done <= 1'b0;
            if (ctrl[`CTRL_HALT] || ctrl[`CTRL_SHUT]) begin
              {mem_io, data_ctl, wr_rd, lock_n} <= `CYC_HALT;
              addr_out  <= 30'h0000_0000;
              byte_en_n <= ctrl[`CTRL_SHUT] ? `BE_SHUT : `BE_HALT;
              halted    <= ctrl[`CTRL_HALT] && nmi_serv;
            end else begin
              // type and lock, held to ready
              {mem_io, data_ctl, wr_rd, lock_n} <= cyc_type;
              addr_out  <= req_addr;
              byte_en_n <= `BE_ALL;
            end
          end else if (!maskable_irq) begin
            irq_taken <= 1'b0;
          end
          if ((ctrl[`CTRL_GO] && !halted) || (maskable_irq && ctrl[`CTRL_IE] && !irq_taken)) begin
            addr_strobe_n <= hold_req && lock_n;
            def_oe_n      <= hold_req && lock_n;
          end
        end
        ST_ADDR: begin
          data_oe_n     <= !(wr_rd && data_ctl);
          // upper half moves to the low lines
          data_out      <= half ? {16'h0000, wdata[31:16]} : wdata;
          addr_strobe_n <= piped ? addr_strobe_n : 1'b1;
          // second half keeps the first half's verdict
          fill_ok       <= half ? fill_ok : 1'b1;
          state         <= ST_WAIT;
        end
        ST_WAIT, ST_INTA2: begin
          if (!next_addr_req_n && !piped && ctrl[`CTRL_GO] && ready_n) begin
            piped         <= 1'b1;
            addr_strobe_n <= 1'b0;
          end
          if (done) begin
            if (fillable(cyc_type) && data_ctl)
              fill_ok <= fill_ok && cfg_a[`CFG_A_KEN] && !cacheable_n;
            if (is_read && !narrow_bus_size_n && !half)
              rdata[15:0] <= data_in[15:0];
            else if (is_read && half)
              rdata[31:16] <= data_in[15:0];
            else if (is_read)
              rdata <= data_in;
            if (!lock_n && !mem_io && !data_ctl && state == ST_ADDR + 3'd1 && !half) begin
              // second acknowledge with its own strobe
              half          <= 1'b1;
              addr_strobe_n <= 1'b0;
              state         <= ST_ADDR;
            end else if (!narrow_bus_size_n && !half && mem_io) begin
              half          <= 1'b1;
              addr_strobe_n <= 1'b0;
              state         <= ST_ADDR;
            end else begin
              if (!mem_io && !data_ctl)
                vector <= data_in[7:0];
              if (fillable(cyc_type) && fill_ok && cfg_a[`CFG_A_KEN] && !cacheable_n) begin
                fill_done           <= 1'b1;
                way                 <= ~way;
                replace_way         <= way & cfg_b[`CFG_B_TWOWAY];
                replace_way_valid_n <= 1'b0;
              end
              busy          <= 1'b0;
              half          <= 1'b0;
              piped         <= 1'b0;
              addr_strobe_n <= 1'b1;
              data_oe_n     <= 1'b1;
              lock_n        <= 1'b1;
              state         <= ST_IDLE;
            end
          end
        end
        ST_GRANT: begin
          replace_way_valid_n <= 1'b1;
          if (!hold_req) begin
            bus_grant_ack <= 1'b0;
            def_oe_n      <= 1'b0;
            state         <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (state == ST_IDLE)
        replace_way_valid_n <= 1'b1;
    end
  end
endmodule

/* verif/local_bus_if_chk.sv */
// Checker for the local-bus block: cycle codes, strobe, grant, cache pins.
// Assumes binding to local_bus_if; sees its ports only.
`timescale 1ns/100ps
`include "cpu_bus_defs.vh"
module local_bus_if_chk (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // Cycle definition
  input wire [29:0] addr_out,
  input wire [3:0]  byte_en_n,
  input wire        mem_io,
  input wire        data_ctl,
  input wire        wr_rd,
  input wire        lock_n,
  input wire        addr_strobe_n,
  input wire        def_oe_n,
  input wire        data_oe_n,
  // Control and cache
  input wire        ready_n,
  input wire        next_addr_req_n,
  input wire        bus_grant_ack,
  input wire        replace_way_valid_n,
  input wire        cache_flush,
  input wire        flush_n
);
  wire [3:0] code;
  assign code = {mem_io, data_ctl, wr_rd, lock_n};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Start of an unpipelined cycle, and its first wait clock
  sequence strobe_start;
    $fell(addr_strobe_n) ##0 next_addr_req_n;
  endsequence
  sequence held_wait;
    strobe_start ##1 ready_n;
  endsequence
  a_code_legal: assert property (!addr_strobe_n |-> code inside {`CYC_INTA,
    `CYC_IO_RD, `CYC_IO_WR, `CYC_CODE_RD, `CYC_HALT, `CYC_LK_RD, `CYC_MEM_RD,
    `CYC_LK_WR, `CYC_MEM_WR}) else $error("illegal cycle code");
  a_halt_zero: assert property ((!addr_strobe_n && code == `CYC_HALT) |->
    addr_out == 30'h0 && byte_en_n inside {`BE_HALT, `BE_SHUT})
    else $error("halt cycle address wrong");
  a_ack_locked: assert property ((!addr_strobe_n && !mem_io && !data_ctl) |-> !lock_n)
    else $error("acknowledge not locked");
  a_grant_float: assert property (bus_grant_ack |-> def_oe_n && data_oe_n)
    else $error("bus driven while granted");
  a_no_grant_lock: assert property ($rose(bus_grant_ack) |-> $past(lock_n))
    else $error("grant while locked");
  a_strobe_once: assert property (strobe_start |=> addr_strobe_n)
    else $error("strobe longer than one clock");
  a_def_hold: assert property (held_wait |-> $stable({mem_io, data_ctl, wr_rd, addr_out}))
    else $error("definition changed in wait");
  a_read_float: assert property ((!addr_strobe_n && !wr_rd) |-> data_oe_n)
    else $error("data driven on read");
  a_fill_read: assert property (!replace_way_valid_n |-> !wr_rd && mem_io)
    else $error("replace valid outside fill");
  a_flush_cause: assert property ($rose(cache_flush) |->
    !flush_n || !$past(flush_n) || bus_grant_ack) else $error("flush without cause");
endmodule
bind local_bus_if local_bus_if_chk u_chk (.pclk(pclk), .presetn(presetn),
  .addr_out(addr_out), .byte_en_n(byte_en_n), .mem_io(mem_io), .data_ctl(data_ctl),
  .wr_rd(wr_rd), .lock_n(lock_n), .addr_strobe_n(addr_strobe_n), .def_oe_n(def_oe_n),
  .data_oe_n(data_oe_n), .ready_n(ready_n), .next_addr_req_n(next_addr_req_n),
  .bus_grant_ack(bus_grant_ack), .replace_way_valid_n(replace_way_valid_n),
  .cache_flush(cache_flush), .flush_n(flush_n));

/* verif/sys_logic_model.sv */
// System logic model: ends each strobed cycle with ready and a read word.
// Assumes one strobe per cycle; wait count set by the bench.
`timescale 1ns/100ps
module sys_logic_model #(
  parameter [31:0] RD_WORD = 32'h5a3c_96e1
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Block side
  input  wire        addr_strobe_n,
  input  wire [1:0]  waits,
  output reg         ready_n,
  output reg  [31:0] data_in
);
  reg [1:0] cnt;
  reg       busy;
  // Data lines toggle when not answering, so stale data matches the read word every other clock
  // ready ends cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy    <= 1'b0;
      cnt     <= 2'b00;
      ready_n <= 1'b1;
      data_in <= ~RD_WORD;
    end else begin
      ready_n <= 1'b1;
      data_in <= ~data_in;
      if (busy && cnt == 2'b00) begin
        busy    <= 1'b0;
        ready_n <= 1'b0;
        data_in <= RD_WORD;
      end else if (busy) begin
        cnt <= cnt - 2'b01;
      end else if (!addr_strobe_n) begin
        busy <= 1'b1;
        cnt  <= waits;
      end
    end
  end
endmodule

/* verif/local_bus_if_bench.sv */
// Bench for the local-bus block: APB master, system model, result queue.
// Assumes design, header and checker compiled first.
`timescale 1ns/100ps
`include "cpu_bus_defs.vh"
module local_bus_if_bench;
  localparam [31:0] RW = 32'h5a3c_96e1;
  reg         pclk, presetn, psel, penable, pwrite, hold_req, nmi, saw_fl;
  reg         next_addr_req_n, narrow_bus_size_n, maskable_irq, cacheable_n, flush_n;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, seed, wexp, rdv;
  reg  [1:0]  waits;
  reg  [3:0]  lcode, lbe;
  reg  [64:0] expq[$];
  reg  [64:0] e;
  reg  [3:0]  codes[0:8];
  wire [31:0] prdata, data_in, data_out;
  wire [29:0] addr_out;
  wire [3:0]  byte_en_n;
  wire        pready, pslverr, data_oe_n, mem_io, data_ctl, wr_rd, lock_n;
  wire        addr_strobe_n, def_oe_n, ready_n, bus_grant_ack, cache_flush;
  wire        replace_way, replace_way_valid_n, replace_oe_n;
  integer     fails, checked, cyc, nstb, n0, i;
  local_bus_if u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .addr_out(addr_out), .byte_en_n(byte_en_n), .mem_io(mem_io), .data_ctl(data_ctl),
    .wr_rd(wr_rd), .lock_n(lock_n), .addr_strobe_n(addr_strobe_n), .def_oe_n(def_oe_n),
    .ready_n(ready_n), .next_addr_req_n(next_addr_req_n),
    .narrow_bus_size_n(narrow_bus_size_n), .hold_req(hold_req),
    .bus_grant_ack(bus_grant_ack), .maskable_irq(maskable_irq), .nmi(nmi),
    .cacheable_n(cacheable_n), .flush_n(flush_n), .replace_way(replace_way),
    .replace_way_valid_n(replace_way_valid_n), .replace_oe_n(replace_oe_n),
    .cache_flush(cache_flush));
  sys_logic_model #(.RD_WORD(RW)) u_sys (.pclk(pclk), .presetn(presetn),
    .addr_strobe_n(addr_strobe_n), .waits(waits), .ready_n(ready_n), .data_in(data_in));
  // Clock, 10 ns period
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic [31:0] xs(input [31:0] v);
    reg [31:0] x;
    begin
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  task chk(input [8*8-1:0] n, input [31:0] ex, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== ex) begin
        fails = fails + 1;
        $display("[FAIL] %0s exp %h got %h", n, ex, g);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // One APB transfer, held until pready
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (!pready) @(posedge pclk);
      rdv = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] ex, input [31:0] m, input er);
    begin
      expq.push_back({er, m, ex & m});
      apb(1'b0, a, 32'h0000_0000);
    end
  endtask
  task wait_idle;
    begin
      rd(`REG_STATUS, 32'h0000_0000, 32'h0000_0000, 1'b0);
      while (rdv[1]) rd(`REG_STATUS, 32'h0000_0000, 32'h0000_0000, 1'b0);
    end
  endtask
  task nmi_edge;
    begin
      nmi <= 1'b0;
      repeat (8) @(posedge pclk);
      nmi <= 1'b1;
      repeat (9) @(posedge pclk);
    end
  endtask
  // Read results, strobe capture, write data and timeout
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (psel && penable && pready && !pwrite) begin
      e = expq.pop_front();
      chk("prdata", e[31:0], prdata & e[63:32]);
      chk("pslverr", 32'(e[64]), 32'(pslverr));
    end
    if (!addr_strobe_n) begin
      nstb = nstb + 1;
      lcode = {mem_io, data_ctl, wr_rd, lock_n};
      lbe = byte_en_n;
    end
    if (!ready_n && !data_oe_n && data_ctl && wr_rd) chk("data_out", wexp, data_out);
    if (cache_flush) saw_fl = 1'b1;
    if (cyc == 30000) begin
      fails = fails + 1;
      give_verdict;
    end
  end
  initial begin
    codes = '{`CYC_IO_RD, `CYC_IO_WR, `CYC_CODE_RD, `CYC_HALT, `CYC_HALT,
      `CYC_LK_RD, `CYC_MEM_RD, `CYC_LK_WR, `CYC_MEM_WR};
    {presetn, psel, penable, pwrite, hold_req, nmi, maskable_irq, saw_fl} = 8'h00;
    {next_addr_req_n, narrow_bus_size_n, cacheable_n, flush_n} = 4'hf;
    {paddr, pwdata, waits, fails, checked, cyc, nstb, wexp} = 0;
    seed = 32'hecc0_6920;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("rpl_oe", 32'h1, 32'(replace_oe_n));
    flush_n <= 1'b0;
    repeat (4) @(posedge pclk);
    flush_n <= 1'b1;
    chk("flush", 32'h0, 32'(saw_fl));
    apb(1'b1, `REG_CFG_A, 32'h0000_0007);
    apb(1'b1, `REG_CFG_B, 32'h0000_0003);
    flush_n <= 1'b0;
    repeat (4) @(posedge pclk);
    flush_n <= 1'b1;
    chk("flush", 32'h1, 32'(saw_fl));
    chk("rpl_oe", 32'h0, 32'(replace_oe_n));
    cacheable_n <= 1'b0;
    rd(12'h100, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    // Every cycle code but acknowledge; index 6 runs on the narrow bus, cache enable held low
    for (i = 0; i < 9; i = i + 1) begin
      seed = xs(seed);
      waits <= seed[1:0];
      narrow_bus_size_n <= (i != 6);
      apb(1'b1, `REG_CYCLE, {28'h0, codes[i]});
      apb(1'b1, `REG_ADDR, seed);
      seed = xs(seed);
      wexp = seed;
      apb(1'b1, `REG_WDATA, wexp);
      n0 = nstb;
      apb(1'b1, `REG_CTRL, (i == 3) ? 32'h9 : (i == 4) ? 32'h11 : 32'h1);
      saw_fl = 1'b0;
      hold_req <= (i == 5);
      wait_idle;
      chk("code", 32'(codes[i]), 32'(lcode));
      chk("strobes", n0 + 1 + (i == 6), nstb);
      rd(`REG_STATUS, (i == 2 || i == 6) ? 32'h0000_0008 : 32'h0000_0000, 32'h0000_0008, 1'b0);
      if (i == 3 || i == 4) chk("be", (i == 3) ? `BE_HALT : `BE_SHUT, 32'(lbe));
      if (i == 6) rd(`REG_RDATA, {RW[15:0], RW[15:0]}, 32'hffff_ffff, 1'b0);
      else if (!codes[i][1]) rd(`REG_RDATA, RW, 32'hffff_ffff, 1'b0);
      while (hold_req && !bus_grant_ack) @(posedge pclk);
      @(posedge pclk);
      if (hold_req) chk("float", 32'h3, {30'h0, def_oe_n, data_oe_n});
      if (hold_req) chk("flush", 32'h1, 32'(saw_fl));
      hold_req <= 1'b0;
    end
    narrow_bus_size_n <= 1'b1;
    // Maskable request held until the first acknowledge starts
    n0 = nstb;
    apb(1'b1, `REG_CTRL, 32'h0000_0002);
    maskable_irq <= 1'b1;
    while (nstb == n0) @(posedge pclk);
    maskable_irq <= 1'b0;
    chk("ack", 32'(`CYC_INTA), 32'(lcode));
    while (nstb < n0 + 2) @(posedge pclk);
    wait_idle;
    chk("acks", n0 + 2, nstb);
    rd(`REG_IRQ, {24'h0, RW[7:0]}, 32'h0000_00ff, 1'b0);
    // Non-maskable edges: service, one stored, released by returns
    n0 = nstb;
    nmi_edge;
    rd(`REG_STATUS, 32'h0000_0020, 32'h0000_0030, 1'b0);
    rd(`REG_IRQ, 32'h0000_0002, 32'h0000_00ff, 1'b0);
    nmi_edge;
    nmi_edge;
    rd(`REG_STATUS, 32'h0000_0030, 32'h0000_0030, 1'b0);
    chk("strobes", n0, nstb);
    apb(1'b1, `REG_CTRL, 32'h0000_0004);
    rd(`REG_STATUS, 32'h0000_0020, 32'h0000_0030, 1'b0);
    // Halt inside service: neither a start nor an edge restarts, a request does
    apb(1'b1, `REG_CTRL, 32'h0000_0009);
    wait_idle;
    n0 = nstb;
    apb(1'b1, `REG_CTRL, 32'h0000_0001);
    nmi_edge;
    rd(`REG_STATUS, 32'h0000_0070, 32'h0000_0072, 1'b0);
    chk("strobes", n0, nstb);
    apb(1'b1, `REG_CTRL, 32'h0000_0002);
    maskable_irq <= 1'b1;
    while (nstb == n0) @(posedge pclk);
    maskable_irq <= 1'b0;
    wait_idle;
    rd(`REG_STATUS, 32'h0000_0030, 32'h0000_0070, 1'b0);
    apb(1'b1, `REG_CTRL, 32'h0000_0004);
    rd(`REG_STATUS, 32'h0000_0020, 32'h0000_0030, 1'b0);
    apb(1'b1, `REG_CTRL, 32'h0000_0004);
    rd(`REG_STATUS, 32'h0000_0000, 32'h0000_0030, 1'b0);
    repeat (2) @(posedge pclk);
    give_verdict;
  end
endmodule
